// ---- hw/csm_dev_end.sv ----
/*
  Converter end: serial target, register file, measurement sequencer and
  shield routing. Assumes an analog front end on the user-side ports that
  answers each conv_start_q pulse with one conv_done pulse.
*/
`timescale 1ns/1ps
module csm_dev_end #(
  parameter logic [15:0] VENDOR_CODE = 16'h0A5A, // arbitrary value
  parameter logic [15:0] PART_CODE = 16'h0101 // arbitrary value
) (
  input wire logic clk_sys,
  input wire logic rst,
  csm_if.dev bus,
  output logic conv_start_q,
  output logic [1:0] conv_pos_q,
  output logic [2:0] conv_neg_q,
  output logic [4:0] conv_dac_q,
  output logic conv_diff_q,
  output logic [1:0] shield_one_ch_q,
  output logic [1:0] shield_two_ch_q,
  output logic shield_tie_q,
  output logic shield_two_float_q,
  input wire logic conv_done,
  input wire logic [csm_pkg::RES_W-1:0] conv_result
);
  import csm_pkg::*;

  typedef enum {T_IDLE, T_RX, T_RACK, T_TX, T_TACK} csm_tst_t;
  typedef enum {Q_IDLE, Q_WAIT} csm_qst_t;

  // ----------------------------------------------------------------
  // pin synchronisers and line events
  // ----------------------------------------------------------------
  logic [2:0] scl_s_q;
  logic [2:0] sda_s_q;
  logic scl_rise, scl_fall, start_ev, stop_ev;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      scl_s_q <= 3'h7;
      sda_s_q <= 3'h7;
    end else begin
      scl_s_q <= {scl_s_q[1:0], bus.scl};
      sda_s_q <= {sda_s_q[1:0], bus.sda};
    end
  end

  assign scl_rise = scl_s_q[1] & ~scl_s_q[2];
  assign scl_fall = ~scl_s_q[1] & scl_s_q[2];
  assign start_ev = scl_s_q[1] & scl_s_q[2] & ~sda_s_q[1] & sda_s_q[2];
  assign stop_ev = scl_s_q[1] & scl_s_q[2] & sda_s_q[1] & ~sda_s_q[2];

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic [7:0] ptr_q;
  logic [15:0] cfg_q [SLOTS];
  logic rpt_q;
  logic [3:0] trig_q, done_q, clr_q;
  logic [RES_W-1:0] res_q [SLOTS];
  logic [7:0] lsb_hold_q [SLOTS];
  logic wr_q;
  logic [15:0] wdata_q;
  logic [15:0] rd_word;
  logic cmp;
  logic [1:0] slot_q;

  function automatic logic ptr_ok(input logic [7:0] p);
    return p <= PTR_CTRL || p == PTR_VEND || p == PTR_PART;
  endfunction : ptr_ok

  function automatic logic ptr_wr(input logic [7:0] p);
    return p >= PTR_CFG0 && p <= PTR_CTRL;
  endfunction : ptr_wr

  // slot zero sits in the top bit of the trigger and done fields
  function automatic logic [3:0] rev4(input logic [3:0] v);
    return {v[0], v[1], v[2], v[3]};
  endfunction : rev4

  always_comb begin
    rd_word = 16'h0000;
    if (ptr_q < PTR_CFG0) begin
      if (!ptr_q[0]) begin
        rd_word = res_q[ptr_q[2:1]][RES_W-1:8];
      end else begin
        rd_word = {lsb_hold_q[ptr_q[2:1]], 8'h00};
      end
    end else if (ptr_q < PTR_CTRL) begin
      rd_word = cfg_q[ptr_q[1:0]];
    end else if (ptr_q == PTR_CTRL) begin
      rd_word = {7'h00, rpt_q, rev4(trig_q), rev4(done_q)};
    end else if (ptr_q == PTR_VEND) begin
      rd_word = VENDOR_CODE;
    end else if (ptr_q == PTR_PART) begin
      rd_word = PART_CODE;
    end
  end

  // ----------------------------------------------------------------
  // serial target
  // ----------------------------------------------------------------
  csm_tst_t tst_q;
  logic [3:0] bcnt_q;
  logic [7:0] sh_q, hi_q, txb_q;
  logic [15:0] tx_q;
  logic [1:0] phase_q;
  logic rw_q, tx_lo_q, mack_q, sda_oe_q;

  assign bus.dev_sda_oe = sda_oe_q;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tst_q <= T_IDLE;
      bcnt_q <= 4'h0;
      sh_q <= 8'h00;
      hi_q <= 8'h00;
      txb_q <= 8'h00;
      tx_q <= 16'h0000;
      phase_q <= 2'h0;
      rw_q <= 1'b0;
      tx_lo_q <= 1'b0;
      mack_q <= 1'b0;
      sda_oe_q <= 1'b0;
      ptr_q <= PTR_RST;
      wr_q <= 1'b0;
      wdata_q <= 16'h0000;
      clr_q <= 4'h0;
      for (int i = 0; i < SLOTS; i++) begin
        lsb_hold_q[i] <= 8'h00;
      end
    end else begin
      wr_q <= 1'b0;
      clr_q <= 4'h0;
      if (start_ev) begin
        tst_q <= T_RX;
        bcnt_q <= 4'h0;
        phase_q <= 2'h0;
        sda_oe_q <= 1'b0;
      end else if (stop_ev) begin
        tst_q <= T_IDLE;
        sda_oe_q <= 1'b0;
      end else begin
        unique case (tst_q)
          T_IDLE: begin
          end
          T_RX: begin
            if (scl_rise) begin
              sh_q <= {sh_q[6:0], sda_s_q[1]};
              bcnt_q <= bcnt_q + 4'h1;
            end else if (scl_fall && bcnt_q == 4'h8) begin
              tst_q <= T_RACK;
              bcnt_q <= 4'h0;
              unique case (phase_q)
                2'h0: begin
                  rw_q <= sh_q[0];
                  if (sh_q[7:1] == TGT_ADDR) begin
                    sda_oe_q <= 1'b1;
                  end else begin
                    tst_q <= T_IDLE;
                  end
                end
                2'h1: begin
                  ptr_q <= sh_q;
                  sda_oe_q <= ptr_ok(sh_q);
                end
                2'h2: begin
                  hi_q <= sh_q;
                  sda_oe_q <= ptr_wr(ptr_q);
                end
                2'h3: begin
                  sda_oe_q <= ptr_wr(ptr_q);
                  wr_q <= ptr_wr(ptr_q);
                  wdata_q <= {hi_q, sh_q};
                end
              endcase
            end
          end
          T_RACK: begin
            if (scl_fall) begin
              sda_oe_q <= 1'b0;
              if (rw_q) begin
                // read starts at the last written pointer
                tst_q <= T_TX;
                tx_q <= rd_word;
                txb_q <= rd_word[15:8];
                sda_oe_q <= ~rd_word[15];
                tx_lo_q <= 1'b0;
                if (ptr_q < PTR_CFG0 && !ptr_q[0]) begin
                  lsb_hold_q[ptr_q[2:1]] <= res_q[ptr_q[2:1]][7:0];
                end
              end else begin
                tst_q <= T_RX;
                phase_q <= (phase_q == 2'h3) ? 2'h2 : phase_q + 2'h1;
              end
            end
          end
          T_TX: begin
            if (scl_fall) begin
              if (bcnt_q == 4'h7) begin
                tst_q <= T_TACK;
                sda_oe_q <= 1'b0;
              end else begin
                bcnt_q <= bcnt_q + 4'h1;
                txb_q <= {txb_q[6:0], 1'b0};
                sda_oe_q <= ~txb_q[6];
              end
            end
          end
          T_TACK: begin
            if (scl_rise) begin
              mack_q <= ~sda_s_q[1];
              // lower half read means the pair is complete
              if (tx_lo_q && ptr_q < PTR_CFG0 && ptr_q[0]) begin
                clr_q[ptr_q[2:1]] <= 1'b1;
              end
            end else if (scl_fall) begin
              bcnt_q <= 4'h0;
              if (!mack_q) begin
                tst_q <= T_IDLE;
              end else if (tx_lo_q) begin
                tst_q <= T_TX;
                tx_q <= rd_word;
                txb_q <= rd_word[15:8];
                sda_oe_q <= ~rd_word[15];
                tx_lo_q <= 1'b0;
                if (ptr_q < PTR_CFG0 && !ptr_q[0]) begin
                  lsb_hold_q[ptr_q[2:1]] <= res_q[ptr_q[2:1]][7:0];
                end
              end else begin
                tst_q <= T_TX;
                txb_q <= tx_q[7:0];
                sda_oe_q <= ~tx_q[7];
                tx_lo_q <= 1'b1;
              end
            end
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // setup and control registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < SLOTS; i++) begin
        cfg_q[i] <= CFG_RST;
      end
      rpt_q <= 1'b0;
      trig_q <= 4'h0;
    end else begin
      if (cmp && !rpt_q) begin
        trig_q[slot_q] <= 1'b0;
      end
      if (wr_q && ptr_q < PTR_CTRL) begin
        cfg_q[ptr_q[1:0]] <= wdata_q;
      end
      // whole control word lands at once, so a fresh trigger wins
      if (wr_q && ptr_q == PTR_CTRL) begin
        rpt_q <= wdata_q[RPT_BIT];
        trig_q <= rev4(wdata_q[TRIG_HI:TRIG_LO]);
      end
    end
  end

  // completion set wins over a read clear in the same cycle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      done_q <= 4'h0;
    end else begin
      done_q <= (done_q & ~clr_q) | ({3'h0, cmp} << slot_q);
    end
  end

  // ----------------------------------------------------------------
  // measurement sequencer
  // ----------------------------------------------------------------
  csm_qst_t qst_q;
  logic [1:0] nxt;
  logic [15:0] ncfg;
  logic [2:0] nneg;
  logic [1:0] npos;
  logic ndiff;

  // round robin so repeat mode serves every triggered slot
  function automatic logic [1:0] pick(input logic [3:0] t,
                                      input logic [1:0] last);
    logic [1:0] k;
    pick = last;
    for (int i = 4; i >= 1; i--) begin
      k = last + 2'(i);
      if (t[k]) begin
        pick = k;
      end
    end
  endfunction : pick

  assign nxt = pick(trig_q, slot_q);
  assign ncfg = cfg_q[nxt];
  assign npos = ncfg[POS_LO+1:POS_LO];
  assign nneg = ncfg[NEG_HI:NEG_LO];
  assign ndiff = nneg < NEG_OFFSET_CAP_DAC;
  assign cmp = (qst_q == Q_WAIT) && conv_done;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      qst_q <= Q_IDLE;
      slot_q <= 2'h3;
      conv_start_q <= 1'b0;
      conv_pos_q <= 2'h0;
      conv_neg_q <= 3'h0;
      conv_dac_q <= 5'h00;
      conv_diff_q <= 1'b0;
      shield_one_ch_q <= 2'h0;
      shield_two_ch_q <= 2'h0;
      shield_tie_q <= 1'b0;
      shield_two_float_q <= 1'b0;
      for (int i = 0; i < SLOTS; i++) begin
        res_q[i] <= '0;
      end
    end else begin
      conv_start_q <= 1'b0;
      unique case (qst_q)
        Q_IDLE: begin
          // repeat mode restarts here even with unread results
          if (|trig_q) begin
            qst_q <= Q_WAIT;
            slot_q <= nxt;
            conv_start_q <= 1'b1;
            conv_pos_q <= npos;
            conv_neg_q <= nneg;
            conv_diff_q <= ndiff;
            conv_dac_q <= (!ndiff && nneg == NEG_OFFSET_CAP_DAC) ?
                          ncfg[DAC_HI:DAC_LO] : 5'h00;
            if (ndiff) begin
              shield_one_ch_q <= (npos < nneg[1:0]) ? npos : nneg[1:0];
              shield_two_ch_q <= (npos < nneg[1:0]) ? nneg[1:0] : npos;
              shield_tie_q <= 1'b0;
              shield_two_float_q <= 1'b0;
            end else begin
              shield_one_ch_q <= npos;
              shield_two_ch_q <= npos;
              shield_tie_q <= nneg != NEG_OFFSET_CAP_DAC;
              shield_two_float_q <= nneg == NEG_OFFSET_CAP_DAC;
            end
          end
        end
        Q_WAIT: begin
          if (conv_done) begin
            res_q[slot_q] <= conv_result;
            qst_q <= Q_IDLE;
          end
        end
      endcase
    end
  end
endmodule : csm_dev_end

// ---- inc/csm_pkg.sv ----
/*
  Shared constants for the capacitance sensor measurement control link:
  target address, register pointers, field positions, reset values and
  bus timing. Assumes a 250 MHz system clock on both ends.
*/
package csm_pkg;
  // ----------------------------------------------------------------
  // bus timing
  // ----------------------------------------------------------------
  localparam int SYS_KHZ = 250000;
  localparam int BUS_KHZ_MIN = 10;
  localparam int BUS_KHZ_MAX = 400;
  // quarter of the fastest serial clock period, rounded up
  localparam int QTR_CYC = (SYS_KHZ + 4 * BUS_KHZ_MAX - 1) /
                           (4 * BUS_KHZ_MAX);
  localparam int FREE_QTRS = 3;

  // ----------------------------------------------------------------
  // target address and register pointers
  // ----------------------------------------------------------------
  localparam logic [6:0] TGT_ADDR = 7'h50;
  localparam logic [7:0] PTR_RST = 8'h00;
  localparam logic [7:0] PTR_RES0 = 8'h00;
  localparam logic [7:0] PTR_CFG0 = 8'h08;
  localparam logic [7:0] PTR_CTRL = 8'h0C;
  localparam logic [7:0] PTR_VEND = 8'hFE;
  localparam logic [7:0] PTR_PART = 8'hFF;

  // ----------------------------------------------------------------
  // fields and reset values
  // ----------------------------------------------------------------
  localparam int SLOTS = 4;
  localparam int RES_W = 24;
  localparam int POS_HI = 15;
  localparam int POS_LO = 13;
  localparam int NEG_HI = 12;
  localparam int NEG_LO = 10;
  localparam int DAC_HI = 9;
  localparam int DAC_LO = 5;
  localparam int RPT_BIT = 8;
  localparam int TRIG_HI = 7;
  localparam int TRIG_LO = 4;
  localparam logic [2:0] NEG_OFFSET_CAP_DAC = 3'h4;
  localparam logic [15:0] CFG_RST = 16'h1C00;

  // ----------------------------------------------------------------
  // host command port
  // ----------------------------------------------------------------
  localparam logic [2:0] HR_PTR = 3'h0;
  localparam logic [2:0] HR_WDATA = 3'h1;
  localparam logic [2:0] HR_CMD = 3'h2;
  localparam logic [2:0] HR_RDATA = 3'h3;
  localparam logic [1:0] OP_WRITE = 2'h0;
  localparam logic [1:0] OP_SETPTR = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
endpackage : csm_pkg

// ---- inc/csm_if.sv ----
/*
  Two-wire serial link between the controller end and the converter end.
  Assumes pull-ups on both lines: an enable high pulls its line low.
*/
`timescale 1ns/1ps
interface csm_if;
  logic host_scl_oe;
  logic host_sda_oe;
  logic dev_sda_oe;
  logic scl;
  logic sda;

  assign scl = ~host_scl_oe;
  assign sda = ~(host_sda_oe | dev_sda_oe);

  modport dev (input scl, input sda, output dev_sda_oe);
  modport host (input scl, input sda, output host_scl_oe,
                output host_sda_oe);
endinterface : csm_if

// ---- hw/csm_host_end.sv ----
/*
  Controller end: runs one register write, pointer set or register read
  on the serial link per command. Assumes software on a plain port with
  one-cycle strobes and read data in the following cycle.
*/
`timescale 1ns/1ps
module csm_host_end #(
  parameter int QTR = csm_pkg::QTR_CYC
) (
  input wire logic clk_sys,
  input wire logic rst,
  csm_if.host bus,
  input wire logic [2:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata
);
  import csm_pkg::*;

  typedef enum {H_IDLE, H_STA, H_LO, H_DAT, H_HI1, H_HI2, H_RS1, H_RS2,
                H_RS3, H_STP1, H_STP2, H_STP3, H_FREE} csm_hst_t;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  csm_hst_t st_q;
  logic [15:0] qc_q;
  logic [1:0] sda_s_q;
  logic [7:0] ptr_q, rx_q;
  logic [15:0] wd_q, rword_q;
  logic [1:0] op_q;
  logic [2:0] bi_q;
  logic [3:0] bc_q;
  logic nack_q, scl_oe_q, sda_oe_q;
  logic tick, go, rx, busy;
  logic [7:0] txb;

  assign bus.host_scl_oe = scl_oe_q;
  assign bus.host_sda_oe = sda_oe_q;
  assign tick = qc_q == 16'h0000;
  assign busy = st_q != H_IDLE;
  assign go = reg_wr && reg_addr == HR_CMD && !busy;
  assign rx = bi_q >= 3'h5;

  always_comb begin
    unique case (bi_q)
      3'h0: txb = {TGT_ADDR, 1'b0};
      3'h1: txb = ptr_q;
      3'h2: txb = wd_q[15:8];
      3'h3: txb = wd_q[7:0];
      3'h4: txb = {TGT_ADDR, 1'b1};
      default: txb = 8'hFF;
    endcase
  end

  // ----------------------------------------------------------------
  // command port; pointer and data are held while a frame runs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ptr_q <= 8'h00;
      wd_q <= 16'h0000;
      reg_rdata <= 16'h0000;
    end else begin
      if (reg_wr && !busy && reg_addr == HR_PTR) begin
        ptr_q <= reg_wdata[7:0];
      end
      if (reg_wr && !busy && reg_addr == HR_WDATA) begin
        wd_q <= reg_wdata;
      end
      reg_rdata <= 16'h0000;
      if (reg_rd) begin
        unique case (reg_addr)
          HR_PTR: reg_rdata <= {8'h00, ptr_q};
          HR_WDATA: reg_rdata <= wd_q;
          HR_CMD: reg_rdata <= {14'h0000, busy, nack_q};
          HR_RDATA: reg_rdata <= rword_q;
          default: reg_rdata <= 16'h0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // bit engine, one state per quarter of the serial clock
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sda_s_q <= 2'h3;
    end else begin
      sda_s_q <= {sda_s_q[0], bus.sda};
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_q <= H_IDLE;
      qc_q <= 16'h0000;
      op_q <= OP_WRITE;
      bi_q <= 3'h0;
      bc_q <= 4'h0;
      rx_q <= 8'h00;
      rword_q <= 16'h0000;
      nack_q <= 1'b0;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else if (st_q == H_IDLE) begin
      if (go) begin
        op_q <= reg_wdata[1:0];
        nack_q <= 1'b0;
        bi_q <= 3'h0;
        bc_q <= 4'h0;
        sda_oe_q <= 1'b1;
        qc_q <= 16'(QTR - 1);
        st_q <= H_STA;
      end
    end else if (!tick) begin
      qc_q <= qc_q - 16'h0001;
    end else begin
      qc_q <= 16'(QTR - 1);
      unique case (st_q)
        H_STA: begin
          scl_oe_q <= 1'b1;
          st_q <= H_LO;
        end
        H_LO: begin
          if (bc_q == 4'h8) begin
            sda_oe_q <= rx && bi_q == 3'h5;
          end else begin
            sda_oe_q <= !rx && !txb[3'h7 - bc_q[2:0]];
          end
          st_q <= H_DAT;
        end
        H_DAT: begin
          scl_oe_q <= 1'b0;
          st_q <= H_HI1;
        end
        H_HI1: st_q <= H_HI2;
        H_HI2: begin
          scl_oe_q <= 1'b1;
          st_q <= H_LO;
          if (bc_q != 4'h8) begin
            rx_q <= {rx_q[6:0], sda_s_q[1]};
            bc_q <= bc_q + 4'h1;
          end else begin
            bc_q <= 4'h0;
            bi_q <= bi_q + 3'h1;
            if (!rx && sda_s_q[1]) begin
              nack_q <= 1'b1;
              st_q <= H_STP1;
            end else if (bi_q == 3'h5) begin
              rword_q[15:8] <= rx_q;
            end else if (bi_q == 3'h6) begin
              rword_q[7:0] <= rx_q;
              st_q <= H_STP1;
            end else if (bi_q == 3'h3 ||
                         (bi_q == 3'h1 && op_q == OP_SETPTR)) begin
              st_q <= H_STP1;
            end else if (bi_q == 3'h1 && op_q == OP_READ) begin
              // the read address byte follows the repeated start
              bi_q <= 3'h4;
              st_q <= H_RS1;
            end else if (bi_q == 3'h1 && op_q != OP_WRITE) begin
              st_q <= H_STP1;
            end
          end
        end
        H_RS1: begin
          sda_oe_q <= 1'b0;
          st_q <= H_RS2;
        end
        H_RS2: begin
          scl_oe_q <= 1'b0;
          st_q <= H_RS3;
        end
        H_RS3: begin
          sda_oe_q <= 1'b1;
          st_q <= H_STA;
        end
        H_STP1: begin
          sda_oe_q <= 1'b1;
          st_q <= H_STP2;
        end
        H_STP2: begin
          scl_oe_q <= 1'b0;
          st_q <= H_STP3;
        end
        H_STP3: begin
          sda_oe_q <= 1'b0;
          bc_q <= 4'h0;
          st_q <= H_FREE;
        end
        H_FREE: begin
          // bus free time before the next start
          bc_q <= bc_q + 4'h1;
          if (bc_q == 4'(FREE_QTRS - 1)) begin
            st_q <= H_IDLE;
          end
        end
        default: st_q <= H_IDLE;
      endcase
    end
  end
endmodule : csm_host_end

// ---- verif/csm_link_assertions.sv ----
/* wire checks on the serial link; takes csm_if lines as inputs */
`timescale 1ns/1ps
module csm_link_assertions (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic host_scl_oe,
  input wire logic host_sda_oe,
  input wire logic dev_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  import csm_pkg::*;
  logic frm_q, scl_q, sda_q;
  logic [3:0] bit_q;
  logic [7:0] adr_q;
  wire st = scl && scl_q && sda_q && !sda;
  wire sp = scl && scl_q && !sda_q && sda;
  wire rise = scl && !scl_q;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      {frm_q, scl_q, sda_q} <= 3'h3;
      bit_q <= 4'h0;
      adr_q <= 8'h00;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      if (st || sp)
        frm_q <= st;
      if (st)
        bit_q <= 4'h0;
      else if (rise && bit_q != 4'hF)
        bit_q <= bit_q + 4'h1;
      // first byte only: bits arrive msb first
      if (rise && bit_q < 4'h8)
        adr_q <= {adr_q[6:0], sda};
    end
  end
  a_lines_reset: assert property (disable iff (1'b0) rst |->
    !host_scl_oe && !host_sda_oe && !dev_sda_oe) else $error("oe in reset");
  a_addr_ack: assert property (rise && bit_q == 4'h8 |->
    sda == (adr_q[7:1] != TGT_ADDR)) else $error("address ack wrong");
  a_dev_sda_low: assert property ($changed(dev_sda_oe) |->
    !scl && !$past(scl)) else $error("device moved sda with scl high");
  a_scl_high_min: assert property ($rose(scl) |-> scl[*6])
    else $error("scl high too short");
  a_scl_low_min: assert property ($fell(scl) |-> !scl[*6])
    else $error("scl low too short");
  a_bus_free: assert property ($rose(sda) && scl |->
    (sda && scl)[*8]) else $error("bus free too short");
  a_scl_in_frame: assert property ($rose(host_scl_oe) |-> frm_q)
    else $error("clock outside frame");
  a_dev_quiet: assert property (!frm_q |-> !dev_sda_oe)
    else $error("device drove idle bus");
endmodule : csm_link_assertions

// ---- verif/cap_sensor_i2c_measure_ctrl_bench.sv ----
/* bench for both link ends; front end modelled as fixed-delay converter */
`timescale 1ns/1ps
module cap_sensor_i2c_measure_ctrl_bench;
  import csm_pkg::*;
  logic clk_sys, rst, reg_wr = 0, reg_rd = 0, conv_done = 0;
  logic [2:0] reg_addr = 0;
  logic [15:0] reg_wdata = 0, reg_rdata, v;
  logic conv_start_q, conv_diff_q, shield_tie_q, shield_two_float_q, nk;
  logic [1:0] conv_pos_q, shield_one_ch_q, shield_two_ch_q;
  logic [2:0] conv_neg_q;
  logic [4:0] conv_dac_q, fe_cnt = 0;
  logic [23:0] conv_result = 0, res;
  logic [27:0] r;
  int err_total = 0, check_count = 0, starts = 0, n0;
  // {setup, diff, dac, shield one, shield two, tie, float}
  logic [27:0] rows[4] = '{28'h10A0141, 28'h5C6002A, 28'h67E081C,
                           28'h0920808};
  csm_if bus ();
  csm_host_end #(.QTR(4)) i_csm_host_end (.clk_sys, .rst, .bus(bus.host),
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
  csm_dev_end #(.VENDOR_CODE(16'h1357)) i_csm_dev_end (.clk_sys, .rst,
    .bus(bus.dev), .conv_start_q, .conv_pos_q, .conv_neg_q, .conv_dac_q,
    .conv_diff_q, .shield_one_ch_q, .shield_two_ch_q, .shield_tie_q,
    .shield_two_float_q, .conv_done, .conv_result); // vendor code arbitrary
  csm_link_assertions i_csm_link_assertions (.clk_sys, .rst,
    .host_scl_oe(bus.host_scl_oe), .host_sda_oe(bus.host_sda_oe),
    .dev_sda_oe(bus.dev_sda_oe), .scl(bus.scl), .sda(bus.sda));
  initial begin
    clk_sys = 0;
    forever #2 clk_sys = ~clk_sys;
  end
  // result tags the start count so a stale pair shows
  always @(posedge clk_sys) begin
    conv_done <= fe_cnt == 5'd1;
    if (fe_cnt != 5'd0)
      fe_cnt <= fe_cnt - 5'd1;
    if (conv_start_q === 1'b1) begin
      fe_cnt <= 5'd20;
      conv_result <= {conv_pos_q, conv_neg_q, conv_dac_q, conv_diff_q,
                      starts[12:0]};
      starts <= starts + 1;
    end
  end
  task automatic final_report;
    if (err_total == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : final_report
  task automatic chk(input string s, input logic [15:0] e, g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic put(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : put
  task automatic get(input logic [2:0] a, output logic [15:0] q);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 q = reg_rdata;
  endtask : get
  task automatic xfer(input logic [7:0] p, input logic [15:0] w,
                      input logic [1:0] op);
    int n;
    put(HR_PTR, {8'h00, p});
    put(HR_WDATA, w);
    put(HR_CMD, {14'h0, op});
    for (n = 0; n < 3000; n++) begin
      get(HR_CMD, v);
      if (v[1] === 1'b0)
        break;
    end
    if (n == 3000) begin
      err_total++;
      final_report();
    end
    nk = v[0];
    get(HR_RDATA, v);
  endtask : xfer
  initial begin
    // rise after time zero so every reset process sees the edge
    rst = 1'b0;
    #1 rst = 1'b1;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      r = rows[i];
      res = {r[26:22], r[10:6], r[11], 13'(i)};
      xfer(PTR_CFG0 + 8'(i), r[27:12], OP_WRITE);
      chk("setup nack", 16'h0, {15'h0, nk});
      xfer(PTR_CTRL, 16'h0080 >> i, OP_WRITE);
      xfer(PTR_CTRL, 16'h0, OP_READ);
      chk("control", 16'h0008 >> i, v);
      chk("front end", {4'h0, r[11:0]}, {4'h0, conv_diff_q, conv_dac_q,
        shield_one_ch_q, shield_two_ch_q, shield_tie_q,
        shield_two_float_q});
      xfer(PTR_RES0 + 8'(2 * i), 16'h0, OP_READ);
      chk("upper", res[23:8], v);
      xfer(PTR_RES0 + 8'(2 * i + 1), 16'h0, OP_READ);
      chk("lower", {res[7:0], 8'h00}, v);
      xfer(PTR_CTRL, 16'h0, OP_READ);
      chk("cleared", 16'h0, v);
    end
    xfer(PTR_VEND, 16'h1234, OP_WRITE);
    chk("ro nack", 16'h1, {15'h0, nk});
    xfer(PTR_VEND, 16'h0, OP_READ);
    chk("vendor", 16'h1357, v);
    xfer(8'h0D, 16'h0, OP_READ);
    chk("unused nack", 16'h1, {15'h0, nk});
    xfer(8'h0D, 16'h0, OP_SETPTR);
    chk("setptr nack", 16'h1, {15'h0, nk});
    xfer(PTR_CTRL, 16'h0, OP_SETPTR);
    chk("setptr ack", 16'h0, {15'h0, nk});
    n0 = starts;
    xfer(PTR_CTRL, 16'h01C0, OP_WRITE);
    xfer(PTR_CTRL, 16'h0, OP_READ);
    chk("repeat", 16'h01CC, v);
    chk("runs", 16'h1, 16'(starts - n0 > 4));
    xfer(PTR_CTRL, 16'h0, OP_WRITE);
    n0 = starts;
    xfer(PTR_CTRL, 16'h0, OP_READ);
    chk("stopped", 16'h000C, v);
    chk("no restart", 16'(n0), 16'(starts));
    get(3'h4, v);
    chk("hole", 16'h0, v);
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    xfer(PTR_CFG0, 16'h0, OP_READ);
    chk("setup reset", CFG_RST, v);
    xfer(PTR_CTRL, 16'h0, OP_READ);
    chk("control reset", 16'h0, v);
    final_report();
  end
endmodule : cap_sensor_i2c_measure_ctrl_bench
